// file: logic/asrc_host.sv
// host side controller driving the asynchronous static memory pins
`timescale 1ns/1ps
module asrc_host #(
  parameter int READ_WAIT = asrc_pkg::READ_WAIT_CYC,
  parameter int WRITE_PULSE = asrc_pkg::WRITE_PULSE_CYC,
  parameter int RECOVER = asrc_pkg::RECOVER_CYC,
  parameter int FLOAT_WAIT = asrc_pkg::FLOAT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire asrc_pkg::asrc_req_s req,
  output logic rsp_valid,
  output logic [asrc_pkg::DATA_W-1:0] rsp_rdata,
  output asrc_pkg::asrc_pins_s mem_pins,
  input wire logic [asrc_pkg::DATA_W-1:0] mem_dq_in,
  output logic [asrc_pkg::DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_READ, ST_WRITE, ST_END, ST_RECOVER
  } asrc_state_e;

  asrc_state_e state_q;
  logic write_q;
  logic load;
  logic [asrc_pkg::CNT_W-1:0] load_val;
  logic done;
  logic sel_n_q;
  logic wr_n_q;
  logic gate_n_q;
  logic [asrc_pkg::ADDR_W-1:0] addr_q;

  assign mem_pins = '{sel_n: sel_n_q, wr_n: wr_n_q, gate_n: gate_n_q, addr: addr_q};

  asrc_wait_cnt #(.W(asrc_pkg::CNT_W)) u_wait (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(load),
    .value(load_val),
    .done(done)
  );

  assign req_ready = (state_q == ST_IDLE);

  // phase sequencing and the wait loaded on leaving setup, read and write
  always_comb
  begin
    load = 1'b0;
    load_val = '0;
    case (state_q)
      ST_IDLE:
        load = 1'b0;
      ST_SETUP:
      begin
        load = 1'b1;
        load_val = write_q ? asrc_pkg::CNT_W'(WRITE_PULSE)
                           : asrc_pkg::CNT_W'(READ_WAIT);
      end
      ST_READ:
        if (done)
        begin
          load = 1'b1;
          load_val = asrc_pkg::CNT_W'(FLOAT_WAIT);
        end
      ST_WRITE:
        if (done)
        begin
          load = 1'b1;
          load_val = asrc_pkg::CNT_W'(RECOVER);
        end
      default:
        load = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= ST_IDLE;
    else
      case (state_q)
        ST_IDLE:
          if (req_valid)
            state_q <= ST_SETUP;
        ST_SETUP:
          state_q <= write_q ? ST_WRITE : ST_READ;
        ST_READ:
          if (done)
            state_q <= ST_RECOVER;
        ST_WRITE:
          if (done)
            state_q <= ST_END;
        ST_END:
          state_q <= ST_RECOVER;
        ST_RECOVER:
          if (done)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
  end

  // address and data latched at acceptance, stable all access
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      write_q <= 1'b0;
      // address kept while select is still low
      if (sel_n_q)
        addr_q <= '0;
      mem_dq_out <= '0;
    end
    else if (req_ready && req_valid)
    begin
      write_q <= req.write;
      addr_q <= req.addr;
      mem_dq_out <= req.wdata;
    end
  end

  // strobes; strobe falls with select so memory never drives on write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sel_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      gate_n_q <= 1'b1;
    end
    else
    begin
      sel_n_q <= !((state_q == ST_SETUP) ||
                   (state_q == ST_READ && !done) ||
                   (state_q == ST_WRITE));
      // strobe rises a cycle before select, ending the write
      wr_n_q <= !((state_q == ST_SETUP && write_q) ||
                  (state_q == ST_WRITE && !done));
      gate_n_q <= !((state_q == ST_SETUP && !write_q) ||
                    (state_q == ST_READ && !done));
    end
  end

  // data driven only while write strobe is low plus one hold cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mem_dq_oe <= 1'b0;
    else
      mem_dq_oe <= (state_q == ST_SETUP && write_q) ||
                   (state_q == ST_WRITE);
  end

  // capture read byte at end of access wait, before deselect
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state_q == ST_READ && done) || (state_q == ST_END);
      if (state_q == ST_READ && done)
        rsp_rdata <= mem_dq_in;
    end
  end
endmodule

// file: inc/asrc_pkg.sv
// package for the asynchronous static memory host port controller
package asrc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 40;
  // faster grade timing in ns
  localparam int SELECT_TO_VALID_DELAY_NS = 70;
  localparam int GATE_TO_VALID_DELAY_NS = 35;
  localparam int DESELECT_FLOAT_DELAY_NS = 25;
  localparam int STROBE_PULSE_WIDTH_NS = 55;
  localparam int SELECT_TO_FINISH_TIME_NS = 65;
  localparam int VALUE_LEAD_TIME_NS = 30;
  localparam int RECOVERY_AFTER_SELECT_NS = 15;
  localparam int VALUE_HOLD_AFTER_SELECT_NS = 10;
  // least times round up, none below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int READ_WAIT_CYC = cyc_up(SELECT_TO_VALID_DELAY_NS);
  localparam int WRITE_PULSE_CYC = cyc_up(SELECT_TO_FINISH_TIME_NS);
  localparam int RECOVER_CYC = cyc_up(RECOVERY_AFTER_SELECT_NS);
  localparam int FLOAT_CYC = cyc_up(DESELECT_FLOAT_DELAY_NS);
  localparam int CNT_W = 4;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_s;

  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic gate_n;
    logic [ADDR_W-1:0] addr;
  } asrc_pins_s;
endpackage

// file: logic/asrc_wait_cnt.sv
// down counter that times the read, write and recovery phases of a memory access
`timescale 1ns/1ps
module asrc_wait_cnt #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cnt_q <= '0;
    else if (load)
      cnt_q <= value;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  // done must not look at load: the caller derives load from done
  assign done = (cnt_q == '0);
endmodule

// file: dv/asrc_host_properties.sv
// assertions on the memory pins of the host port controller
`timescale 1ns/1ps
module asrc_host_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire asrc_pkg::asrc_pins_s mem_pins,
  input wire logic [asrc_pkg::DATA_W-1:0] mem_dq_out,
  input wire logic mem_dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic s, w, g;
  assign s = mem_pins.sel_n;
  assign w = mem_pins.wr_n;
  assign g = mem_pins.gate_n;
  chk_addr_quiet: assert property ($changed(mem_pins.addr) |-> $past(s) || $past(w))
    else $error("address moved during a write");
  chk_read_strobe: assert property (!s && !g |-> w)
    else $error("strobe low in a read");
  chk_no_fight: assert property (mem_dq_oe |-> g)
    else $error("data driven against memory");
  chk_addr_setup: assert property (!s && !w && $past(!s && !w) |-> $stable(mem_pins.addr))
    else $error("address not steady in write");
  chk_pulse_width: assert property ($fell(w) |-> (!s && !w) [*2])
    else $error("write pulse too short");
  chk_data_lead: assert property ($rose(w) |-> $past(mem_dq_oe, 2) && $past(mem_dq_out, 2) == $past(mem_dq_out))
    else $error("write data not set up");
  chk_data_hold: assert property ($rose(w) |-> mem_dq_oe && $stable(mem_dq_out))
    else $error("write data not held");
  chk_recovery: assert property ($rose(s) |=> s)
    else $error("no recovery after deselect");
endmodule

// file: dv/asrc_mem_model.sv
// behavioural static memory on the far side of the host port
`timescale 1ns/1ps
module asrc_mem_model (
  input wire asrc_pkg::asrc_pins_s pins,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  output logic [7:0] dq_in
);
  logic [7:0] mem [0:(1<<asrc_pkg::ADDR_W)-1];
  logic wr_act, drive, ready;
  logic [7:0] rd;
  int access_ns = 70;
  initial ready = 0;
  // unwritten locations read as a fixed marker byte
  initial for (int i = 0; i < (1<<asrc_pkg::ADDR_W); i++) mem[i] = 8'h5a;
  assign wr_act = !pins.sel_n && !pins.wr_n;
  assign drive = !pins.sel_n && !pins.gate_n && pins.wr_n;
  always @(negedge wr_act) if (dq_oe) mem[pins.addr] = dq_out;
  always @(posedge drive)
  begin
    #(access_ns);
    ready = drive;
  end
  always @(negedge drive) ready = 0;
  assign rd = mem[pins.addr];
  // floating lines never show the byte
  assign dq_in = ready ? rd : ~rd;
endmodule

// file: dv/testbench.sv
// self-checking bench for the memory host port controller
`timescale 1ns/1ps
module testbench;
  logic clk, sys_rst, req_valid, req_ready, rsp_valid, mem_dq_oe;
  asrc_pkg::asrc_req_s req;
  asrc_pkg::asrc_pins_s mem_pins;
  logic [7:0] rsp_rdata, mem_dq_in, mem_dq_out, got;
  int err_count = 0;
  int n_compared = 0;
  asrc_host dut_u (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_pins(mem_pins),
    .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
  asrc_mem_model mdl_u (.pins(mem_pins), .dq_out(mem_dq_out), .dq_oe(mem_dq_oe),
    .dq_in(mem_dq_in));
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [7:0] exp, input logic [7:0] act);
    n_compared++;
    if (act !== exp)
    begin
      $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
      err_count++;
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [18:0] a, input logic [7:0] d);
    int i;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk);
    if (i == 20)
    begin
      $display("BAD t=%0t exp=%h got=%h", $time, 1'b1, req_ready);
      err_count++;
      wrap_up();
    end
    req_valid = 1;
    req = '{write: wr, addr: a, wdata: d};
    @(negedge clk);
    req_valid = 0;
    for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge clk);
    if (i == 20)
    begin
      $display("BAD t=%0t exp=%h got=%h", $time, 1'b1, rsp_valid);
      err_count++;
      wrap_up();
    end
    got = rsp_rdata;
    @(negedge clk);
  endtask
  task automatic t_rw();
    xfer(1, 19'h0, 8'h00);
    xfer(1, 19'h7ffff, 8'hff);
    xfer(1, 19'h12345, 8'ha5);
    xfer(0, 19'h7ffff, 8'h00);
    chk(8'hff, got);
    xfer(0, 19'h0, 8'h00);
    chk(8'h00, got);
    xfer(0, 19'h12345, 8'h00);
    chk(8'ha5, got);
    $display("test rw done");
  endtask
  task automatic t_over();
    xfer(1, 19'h00100, 8'h3c);
    xfer(1, 19'h00100, 8'hc3);
    mdl_u.access_ns = 75;
    xfer(0, 19'h00100, 8'h00);
    chk(8'hc3, got);
    mdl_u.access_ns = 70;
    xfer(0, 19'h00200, 8'h00);
    chk(8'h5a, got);
    $display("test overwrite done");
  endtask
  task automatic t_reset();
    req_valid = 1;
    req = '{write: 1'b1, addr: 19'h00300, wdata: 8'h77};
    repeat (2) @(negedge clk);
    req_valid = 0;
    sys_rst = 1;
    @(negedge clk);
    sys_rst = 0;
    chk(8'h0e, {4'h0, mem_pins.sel_n, mem_pins.wr_n, mem_pins.gate_n, mem_dq_oe});
    xfer(1, 19'h00300, 8'h66);
    xfer(0, 19'h00300, 8'h00);
    chk(8'h66, got);
    $display("test reset done");
  endtask
  initial
  begin
    sys_rst = 1;
    req_valid = 0;
    req = '0;
    repeat (16) @(negedge clk);
    sys_rst = 0;
    chk(8'h0e, {4'h0, mem_pins.sel_n, mem_pins.wr_n, mem_pins.gate_n, mem_dq_oe});
    t_rw();
    t_over();
    t_reset();
    wrap_up();
  end
endmodule
bind asrc_host asrc_host_properties chk_u (.clk(clk), .sys_rst(sys_rst),
  .mem_pins(mem_pins), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
